/* common/scsc_consts.vh */
// constants for the scan converter status and control register pair
// assumes byte-wide register addressing at the printed offsets
`ifndef SCSC_CONSTS_VH
`define SCSC_CONSTS_VH

// register byte offsets
`define SCSC_SW_CONTROL_LO     8'h60
`define SCSC_SW_STATUS_LO      8'h62
`define SCSC_SW_STATUS_HI      8'h63
`define SCSC_HW_SHADOW_LO      8'h64
`define SCSC_HW_SHADOW_HI      8'h65

// status low byte bit positions
`define SCSC_ST_READY          0
`define SCSC_ST_ERROR          1
`define SCSC_ST_MCS            2
`define SCSC_ST_MCC            3
`define SCSC_ST_CAL            4
`define SCSC_ST_VSYNC          5
`define SCSC_ST_HSYNC          6

// software control bit position of the clear-complete request
`define SCSC_SC_CLR_COMPLETE   3

// shadow low byte bit positions
`define SCSC_HL_CLK_OFF        1
`define SCSC_HL_ADC_OFF        2
`define SCSC_HL_COMP_OFF       3
`define SCSC_HL_YC_OFF         4
`define SCSC_HL_NOTCH          5
`define SCSC_HL_BANDPASS       6
`define SCSC_HL_PEDESTAL       7

// shadow high byte field positions
`define SCSC_HH_CLKSRC_LSB     0
`define SCSC_HH_SCAN           2
`define SCSC_HH_STD            3
`define SCSC_HH_FMT_LSB        4

// reset values and writable masks
`define SCSC_SHADOW_RESET      16'h0080
`define SCSC_SHADOW_LO_MASK    8'hFE
`define SCSC_SHADOW_HI_MASK    8'h3F

// mode parameter limits
`define SCSC_MIN_IN_COUNT      16'h0020
`define SCSC_MIN_ACTIVE_PCT    7'h14
`define SCSC_MIN_OUT_COUNT     16'h0080

// sync measurement interval
`define SCSC_CLK_KHZ           125000
`define SCSC_MEAS_MS           100
`define SCSC_MEAS_CYCLES       (`SCSC_MEAS_MS * `SCSC_CLK_KHZ)

`endif

/* dv/scsc_host_model.sv */
// host model on the byte register port
// assumes CLK_SYS shared with the block; strobes move on falling edges
`timescale 1ns/1ps
module scsc_host_model (
	input  wire       CLK_SYS,
	input  wire [7:0] REG_RDATA,
	input  wire       REG_RVALID,
	output reg  [7:0] REG_ADDR,
	output reg  [7:0] REG_WDATA,
	output reg        REG_WR,
	output reg        REG_RD
);
	// idle bus at time zero
	initial begin
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
	end
	// one-cycle write; status bytes are never written
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge CLK_SYS);
			REG_ADDR = a;
			REG_WDATA = d;
			REG_WR = 1'b1;
			@(negedge CLK_SYS);
			REG_WR = 1'b0;
			REG_WDATA = ~d;
		end
	endtask
	// one-cycle read; data taken while the answer stands
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(negedge CLK_SYS);
			REG_ADDR = a;
			REG_RD = 1'b1;
			@(negedge CLK_SYS);
			REG_RD = 1'b0;
			d = REG_RVALID ? REG_RDATA : 8'hXX;
		end
	endtask
endmodule

/* dv/scsc_status_control_monitor.sv */
// port assertions for the status word and control shadow
// bound to scsc_status_control; everything on CLK_SYS
`timescale 1ns/1ps
module scsc_status_control_monitor (
	input wire       CLK_SYS,
	input wire       SYS_RST,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire       REG_WR,
	input wire       REG_RD,
	input wire [7:0] REG_RDATA,
	input wire       REG_RVALID,
	input wire       MODE_CHANGE_DETECT,
	input wire       CAL_APPLIED,
	input wire [7:0] FIRMWARE_CHECKSUM,
	input wire       CLOCK_POWER_DOWN,
	input wire       BLACK_PEDESTAL_INSERT,
	input wire [1:0] ENCODER_CLOCK_SOURCE,
	input wire       SCAN_TYPE_SELECT,
	input wire       TV_STANDARD_SELECT,
	input wire [1:0] OUTPUT_FORMAT,
	input wire       TIMING_RELOAD
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// decoded strobes
	wire wr_hi = REG_WR && REG_ADDR == 8'h65;
	wire rd_st = REG_RD && REG_ADDR == 8'h62;
	wire [3:0] mode_now = {TV_STANDARD_SELECT, SCAN_TYPE_SELECT,
		ENCODER_CLOCK_SOURCE};
	// read answers come exactly one cycle later, and only then
	chk_read_answer: assert property (REG_RD |=> REG_RVALID)
		else $error("read strobe not answered");
	chk_no_stray: assert property (!REG_RD |=> !REG_RVALID)
		else $error("answer without read");
	// status fields as seen through reads
	chk_start_seen: assert property (
		MODE_CHANGE_DETECT ##1 rd_st |=> REG_RDATA[2])
		else $error("mode change start not reported");
	chk_cal_copy: assert property (
		rd_st |=> REG_RDATA[4] == $past(CAL_APPLIED, 2))
		else $error("calibration bit wrong");
	chk_sum_copy: assert property (
		REG_RD && REG_ADDR == 8'h63 |=>
		REG_RDATA == $past(FIRMWARE_CHECKSUM, 2))
		else $error("checksum byte wrong");
	// shadow outputs follow writes
	chk_lo_shadow: assert property (
		REG_WR && REG_ADDR == 8'h64 |=>
		CLOCK_POWER_DOWN == $past(REG_WDATA[1]) &&
		BLACK_PEDESTAL_INSERT == $past(REG_WDATA[7]))
		else $error("low shadow outputs wrong");
	chk_hi_shadow: assert property (
		wr_hi |=> {OUTPUT_FORMAT, mode_now} == $past(REG_WDATA[5:0]))
		else $error("high shadow outputs wrong");
	chk_reload_cause: assert property (
		wr_hi |=> TIMING_RELOAD ==
		($past(REG_WDATA[3:0]) != $past(mode_now)))
		else $error("reload pulse wrong");
	chk_reload_only: assert property (
		TIMING_RELOAD |-> $past(wr_hi))
		else $error("reload without write");
endmodule

/* dv/test_scsc_status_control.sv */
// self-checking bench for the status word and control shadow
// host model drives the port; controller inputs move on falling edges
`timescale 1ns/1ps
module test_scsc_status_control;
	reg        clk_sys = 1'b0;
	reg        sys_rst = 1'b1;
	reg        init_done = 1'b0, mcd = 1'b0, pdone = 1'b0, cal = 1'b0;
	reg        vs = 1'b0, hs = 1'b0;
	reg [15:0] input_horizontal_count = 16'h0020, input_vertical_count = 16'h0020, output_pixels_per_line = 16'h0080, output_lines_per_frame = 16'h0080;
	reg [6:0]  haf = 7'h14, vaf = 7'h14;
	reg [7:0]  d, v, sum = 8'h5A;
	wire [7:0] addr, wdata, rdata;
	wire       wr, rd, rvalid, scan, std, reload;
	wire [1:0] clks, fmt;
	wire [6:0] lo;
	integer    n_mismatch = 0, checked = 0, i;
	scsc_status_control #(.MEAS_CYCLES(64)) scsc_status_control_inst (
		.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .INIT_DONE(init_done),
		.MODE_CHANGE_DETECT(mcd), .PARAMS_DONE(pdone), .CAL_APPLIED(cal),
		.INPUT_HORIZONTAL_COUNT(input_horizontal_count), .INPUT_VERTICAL_COUNT(input_vertical_count),
		.HORIZONTAL_ACTIVE_FRACTION(haf), .VERTICAL_ACTIVE_FRACTION(vaf),
		.OUTPUT_PIXELS_PER_LINE(output_pixels_per_line), .OUTPUT_LINES_PER_FRAME(output_lines_per_frame),
		.FIRMWARE_CHECKSUM(sum), .VSYNC_PIN(vs), .HSYNC_PIN(hs),
		.CLOCK_POWER_DOWN(lo[0]), .ADC_POWER_DOWN(lo[1]),
		.COMPOSITE_DAC_POWER_DOWN(lo[2]), .LUMA_CHROMA_DAC_POWER_DOWN(lo[3]),
		.LUMA_NOTCH_INSERT(lo[4]), .CHROMA_BANDPASS_INSERT(lo[5]),
		.BLACK_PEDESTAL_INSERT(lo[6]), .ENCODER_CLOCK_SOURCE(clks),
		.SCAN_TYPE_SELECT(scan), .TV_STANDARD_SELECT(std),
		.OUTPUT_FORMAT(fmt), .TIMING_RELOAD(reload));
	scsc_host_model scsc_host_model_inst (.CLK_SYS(clk_sys),
		.REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd));
	// free-running clock
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	// compare and count
	task chk(input [63:0] what, input [7:0] seen, input [7:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// read one byte and compare it
	task rchk(input [7:0] a, input [7:0] exp);
		begin
			scsc_host_model_inst.rd(a, d);
			chk("regbyte", d, exp);
		end
	endtask
	task give_verdict;
		begin
			$display("comparisons %0d mismatches %0d", checked, n_mismatch);
			if (n_mismatch == 0 && checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// reset values, checksum and an unmapped address
	task t_reset;
		begin
			rchk(8'h64, 8'h80);
			rchk(8'h65, 8'h00);
			rchk(8'h62, 8'h00);
			rchk(8'h63, 8'h5A);
			sum = 8'hC3;
			rchk(8'h63, 8'hC3);
			rchk(8'h70, 8'h00);
		end
	endtask
	// ready, calibration, mode change start/complete and clear request
	task t_flags;
		begin
			@(negedge clk_sys) init_done = 1'b1;
			@(negedge clk_sys) init_done = 1'b0;
			rchk(8'h62, 8'h01);
			cal = 1'b1;
			rchk(8'h62, 8'h11);
			cal = 1'b0;
			rchk(8'h62, 8'h01);
			@(negedge clk_sys) mcd = 1'b1;
			fork
				rchk(8'h62, 8'h05);
				@(negedge clk_sys) mcd = 1'b0;
			join
			rchk(8'h62, 8'h05);
			@(negedge clk_sys) pdone = 1'b1;
			@(negedge clk_sys) pdone = 1'b0;
			rchk(8'h62, 8'h09);
			rchk(8'h62, 8'h09);
			scsc_host_model_inst.wr(8'h60, 8'h08);
			rchk(8'h62, 8'h01);
			rchk(8'h60, 8'h00);
			// completion landing in the clearing cycle wins over the clear
			@(negedge clk_sys) mcd = 1'b1;
			@(negedge clk_sys) mcd = 1'b0;
			scsc_host_model_inst.wr(8'h60, 8'h08);
			pdone = 1'b1;
			@(negedge clk_sys) pdone = 1'b0;
			rchk(8'h62, 8'h09);
			scsc_host_model_inst.wr(8'h60, 8'h08);
			rchk(8'h62, 8'h01);
		end
	endtask
	// each parameter one below its floor, then all at their floors
	task t_error;
		begin
			for (i = 0; i < 7; i = i + 1) begin
				@(negedge clk_sys);
				input_horizontal_count = 16'h0020 - (i == 0);
				input_vertical_count = 16'h0020 - (i == 1);
				haf = 7'h14 - (i == 2);
				vaf = 7'h14 - (i == 3);
				output_pixels_per_line = 16'h0080 - (i == 4);
				output_lines_per_frame = 16'h0080 - (i == 5);
				rchk(8'h62, (i < 6) ? 8'h03 : 8'h01);
			end
		end
	endtask
	// sync activity over three phases of 150 cycles, measured in windows of 64 cycles
	task t_sync;
		begin
			for (i = 0; i < 450; i = i + 1) begin
				@(negedge clk_sys);
				hs = (i < 150) ? ~hs : hs;
				vs = (i >= 150 && i < 300) ? ~vs : vs;
				if (i == 149)
					rchk(8'h62, 8'h41);
				if (i == 299)
					rchk(8'h62, 8'h21);
			end
			rchk(8'h62, 8'h01);
		end
	endtask
	// shadow bits, field codes, write masks and reload pulse
	task t_shadow;
		begin
			for (i = 1; i < 8; i = i + 1) begin
				scsc_host_model_inst.wr(8'h64, 8'h01 << i);
				chk("lo_out", {1'b0, lo}, (8'h01 << i) >> 1);
			end
			scsc_host_model_inst.wr(8'h64, 8'hFF);
			rchk(8'h64, 8'hFE);
			scsc_host_model_inst.wr(8'h65, 8'hFF);
			chk("reload", {7'h00, reload}, 8'h01);
			rchk(8'h65, 8'h3F);
			for (i = 0; i < 4; i = i + 1) begin
				v = {2'b00, i[1:0], i[0], ~i[0], i == 2, i == 1};
				scsc_host_model_inst.wr(8'h65, v);
				chk("hi_out", {2'b00, fmt, std, scan, clks}, v);
				chk("reload", {7'h00, reload}, 8'h01);
			end
			scsc_host_model_inst.wr(8'h65, v ^ 8'h10);
			chk("reload", {7'h00, reload}, 8'h00);
		end
	endtask
	// main sequence
	initial begin
		repeat (12) @(negedge clk_sys);
		sys_rst = 1'b0;
		t_reset;
		t_flags;
		t_error;
		t_sync;
		t_shadow;
		give_verdict;
	end
	// watchdog, well beyond the roughly 570 cycles of the tests
	initial begin
		#100000;
		n_mismatch = n_mismatch + 1;
		give_verdict;
	end
endmodule
bind scsc_status_control scsc_status_control_monitor
	scsc_status_control_monitor_inst (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
	.MODE_CHANGE_DETECT(MODE_CHANGE_DETECT), .CAL_APPLIED(CAL_APPLIED),
	.FIRMWARE_CHECKSUM(FIRMWARE_CHECKSUM),
	.CLOCK_POWER_DOWN(CLOCK_POWER_DOWN),
	.BLACK_PEDESTAL_INSERT(BLACK_PEDESTAL_INSERT),
	.ENCODER_CLOCK_SOURCE(ENCODER_CLOCK_SOURCE),
	.SCAN_TYPE_SELECT(SCAN_TYPE_SELECT),
	.TV_STANDARD_SELECT(TV_STANDARD_SELECT),
	.OUTPUT_FORMAT(OUTPUT_FORMAT), .TIMING_RELOAD(TIMING_RELOAD));

/* hdl/scsc_status_control.v */
// status word and hardware control shadow of the scan converter
// assumes a byte register port on CLK_SYS and controller event strobes
// from logic on the same clock; sync pins arrive asynchronously
// How it works
// - ready reads 0 during controller initialisation, 1 once finished
// - error set when input counts, active fractions or output counts small
// - mode-change-start set when controller detects input mode change
// - mode-change-start cleared only when parameters are all computed
// - mode-change-complete set at finish, held until clear request
// - calibration bit 0 on defaults, 1 once calibration applied
// - vsync activity bit reports activity in last 100ms interval
// - hsync activity bit reports activity in last 100ms interval
// - status high byte shows controller program checksum
// - low bits 1 and 2 power down clocks and converter
// - low bits 3 and 4 power down composite and luma/chroma DACs
// - low bits 5 and 6 insert notch and bandpass filters
// - low bit 7 inserts the black pedestal
// - two-bit field selects encoder clock reference source
// - high bit 2 selects scan type, bit 3 selects standard
// - output format field chooses Y/C, RGB or YUV
// - clear request clears complete flag and then returns to 0
// - clock, scan or standard change reloads output timing defaults
`timescale 1ns/1ps
`include "scsc_consts.vh"

module scsc_status_control #(
	parameter MEAS_CYCLES = `SCSC_MEAS_CYCLES
) (
	input  wire        CLK_SYS,
	input  wire        SYS_RST,
	input  wire [7:0]  REG_ADDR,
	input  wire [7:0]  REG_WDATA,
	input  wire        REG_WR,
	input  wire        REG_RD,
	output reg  [7:0]  REG_RDATA,
	output reg         REG_RVALID,
	input  wire        INIT_DONE,
	input  wire        MODE_CHANGE_DETECT,
	input  wire        PARAMS_DONE,
	input  wire        CAL_APPLIED,
	input  wire [15:0] INPUT_HORIZONTAL_COUNT,
	input  wire [15:0] INPUT_VERTICAL_COUNT,
	input  wire [6:0]  HORIZONTAL_ACTIVE_FRACTION,
	input  wire [6:0]  VERTICAL_ACTIVE_FRACTION,
	input  wire [15:0] OUTPUT_PIXELS_PER_LINE,
	input  wire [15:0] OUTPUT_LINES_PER_FRAME,
	input  wire [7:0]  FIRMWARE_CHECKSUM,
	input  wire        VSYNC_PIN,
	input  wire        HSYNC_PIN,
	output wire        CLOCK_POWER_DOWN,
	output wire        ADC_POWER_DOWN,
	output wire        COMPOSITE_DAC_POWER_DOWN,
	output wire        LUMA_CHROMA_DAC_POWER_DOWN,
	output wire        LUMA_NOTCH_INSERT,
	output wire        CHROMA_BANDPASS_INSERT,
	output wire        BLACK_PEDESTAL_INSERT,
	output wire [1:0]  ENCODER_CLOCK_SOURCE,
	output wire        SCAN_TYPE_SELECT,
	output wire        TV_STANDARD_SELECT,
	output wire [1:0]  OUTPUT_FORMAT,
	output reg         TIMING_RELOAD
);

	// status flags
	reg        ready_r;
	reg        error_r;
	reg        mode_change_start_r;
	reg        mode_change_complete_r;
	reg        calibration_acquired_r;
	reg        vertical_sync_activity_r;
	reg        horizontal_sync_activity_r;
	reg [7:0]  firmware_checksum_r;
	reg        clear_complete_request_r;

	// control shadow bytes
	reg [7:0]  shadow_lo_r;
	reg [7:0]  shadow_hi_r;
	reg [7:0]  shadow_hi_nxt;

	// sync pin synchronisers and edge history
	reg        vs_meta_r;
	reg        vs_sync_r;
	reg        vs_prev_r;
	reg        hs_meta_r;
	reg        hs_sync_r;
	reg        hs_prev_r;
	reg        vs_seen_r;
	reg        hs_seen_r;
	reg [31:0] meas_cnt_r;
	reg [1:0]  sync_fill_r;

	wire       wr_ctrl;
	wire       wr_lo;
	wire       wr_hi;
	wire       meas_end;
	wire       vs_edge;
	wire       hs_edge;
	wire       param_bad;
	wire       complete_clear;
	wire       sync_armed;

	// shadow reset word, split into its two bytes at reset
	localparam [15:0] SHADOW_RESET = `SCSC_SHADOW_RESET;

	// a count below its floor flags the mode as not computable
	function below16;
		input [15:0] value;
		input [15:0] floor;
		begin
			below16 = (value < floor);
		end
	endfunction

	assign wr_ctrl  = REG_WR && (REG_ADDR == `SCSC_SW_CONTROL_LO);
	assign wr_lo    = REG_WR && (REG_ADDR == `SCSC_HW_SHADOW_LO);
	assign wr_hi    = REG_WR && (REG_ADDR == `SCSC_HW_SHADOW_HI);
	assign meas_end = (meas_cnt_r == MEAS_CYCLES - 1);
	// edges count only once the history holds real pin samples, so a pin
	// idling high gives no false activity right after reset
	assign sync_armed = (sync_fill_r == 2'b11);
	assign vs_edge  = sync_armed && (vs_sync_r ^ vs_prev_r);
	assign hs_edge  = sync_armed && (hs_sync_r ^ hs_prev_r);

	// error condition over the mode parameters
	assign param_bad =
		below16(INPUT_HORIZONTAL_COUNT, `SCSC_MIN_IN_COUNT) ||
		below16(INPUT_VERTICAL_COUNT, `SCSC_MIN_IN_COUNT) ||
		(HORIZONTAL_ACTIVE_FRACTION < `SCSC_MIN_ACTIVE_PCT) ||
		(VERTICAL_ACTIVE_FRACTION < `SCSC_MIN_ACTIVE_PCT) ||
		below16(OUTPUT_PIXELS_PER_LINE, `SCSC_MIN_OUT_COUNT) ||
		below16(OUTPUT_LINES_PER_FRAME, `SCSC_MIN_OUT_COUNT);

	// the pending clear request is serviced one cycle after it is taken
	assign complete_clear = clear_complete_request_r;

	// ready, error, checksum and calibration tracking
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ready_r                <= 1'b0;
			error_r                <= 1'b0;
			firmware_checksum_r    <= 8'h00;
			calibration_acquired_r <= 1'b0;
		end else begin
			if (INIT_DONE)
				ready_r <= 1'b1;
			error_r                <= param_bad;
			firmware_checksum_r    <= FIRMWARE_CHECKSUM;
			calibration_acquired_r <= CAL_APPLIED;
		end
	end

	// mode change start and complete; a new event wins over a clear
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			mode_change_start_r    <= 1'b0;
			mode_change_complete_r <= 1'b0;
		end else begin
			if (MODE_CHANGE_DETECT)
				mode_change_start_r <= 1'b1;
			else if (PARAMS_DONE)
				mode_change_start_r <= 1'b0;
			if (PARAMS_DONE && mode_change_start_r)
				mode_change_complete_r <= 1'b1;
			else if (complete_clear)
				mode_change_complete_r <= 1'b0;
		end
	end

	// clear request bit: set by a host write of 1, dropped by the block
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			clear_complete_request_r <= 1'b0;
		end else if (wr_ctrl && REG_WDATA[`SCSC_SC_CLR_COMPLETE]) begin
			clear_complete_request_r <= 1'b1;
		end else begin
			clear_complete_request_r <= 1'b0;
		end
	end

	// two-flop synchronisers for the sync pins, then edge history
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			vs_meta_r <= 1'b0;
			vs_sync_r <= 1'b0;
			vs_prev_r <= 1'b0;
			hs_meta_r <= 1'b0;
			hs_sync_r <= 1'b0;
			hs_prev_r <= 1'b0;
		end else begin
			vs_meta_r <= VSYNC_PIN;
			vs_sync_r <= vs_meta_r;
			vs_prev_r <= vs_sync_r;
			hs_meta_r <= HSYNC_PIN;
			hs_sync_r <= hs_meta_r;
			hs_prev_r <= hs_sync_r;
		end
	end

	// settle count after reset: three edges fill the synchroniser history
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			sync_fill_r <= 2'b00;
		end else if (!sync_armed) begin
			sync_fill_r <= sync_fill_r + 2'b01;
		end
	end

	// measurement window; activity seen in a window is published at its end
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			meas_cnt_r                 <= 32'h00000000;
			vs_seen_r                  <= 1'b0;
			hs_seen_r                  <= 1'b0;
			vertical_sync_activity_r   <= 1'b0;
			horizontal_sync_activity_r <= 1'b0;
		end else if (meas_end) begin
			meas_cnt_r                 <= 32'h00000000;
			vertical_sync_activity_r   <= vs_seen_r | vs_edge;
			horizontal_sync_activity_r <= hs_seen_r | hs_edge;
			vs_seen_r                  <= 1'b0;
			hs_seen_r                  <= 1'b0;
		end else begin
			meas_cnt_r <= meas_cnt_r + 32'h00000001;
			if (vs_edge)
				vs_seen_r <= 1'b1;
			if (hs_edge)
				hs_seen_r <= 1'b1;
		end
	end

	// next value of the high shadow byte, reserved bits kept at zero
	always @* begin
		shadow_hi_nxt = shadow_hi_r;
		if (wr_hi)
			shadow_hi_nxt = REG_WDATA & `SCSC_SHADOW_HI_MASK;
	end

	// control shadow registers and output-mode reload strobe
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			shadow_lo_r   <= SHADOW_RESET[7:0];
			shadow_hi_r   <= SHADOW_RESET[15:8];
			TIMING_RELOAD <= 1'b0;
		end else begin
			if (wr_lo)
				shadow_lo_r <= REG_WDATA & `SCSC_SHADOW_LO_MASK;
			shadow_hi_r   <= shadow_hi_nxt;
			TIMING_RELOAD <= (shadow_hi_nxt[3:0] != shadow_hi_r[3:0]);
		end
	end

	// read port; reads change nothing, status writes are ignored
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				case (REG_ADDR)
				`SCSC_SW_CONTROL_LO: begin
					REG_RDATA <= {4'h0, clear_complete_request_r, 3'h0};
				end
				`SCSC_SW_STATUS_LO: begin
					REG_RDATA <= {1'b0,
						horizontal_sync_activity_r,
						vertical_sync_activity_r,
						calibration_acquired_r,
						mode_change_complete_r,
						mode_change_start_r,
						error_r,
						ready_r};
				end
				`SCSC_SW_STATUS_HI: begin
					REG_RDATA <= firmware_checksum_r;
				end
				`SCSC_HW_SHADOW_LO: begin
					REG_RDATA <= shadow_lo_r;
				end
				`SCSC_HW_SHADOW_HI: begin
					REG_RDATA <= shadow_hi_r;
				end
				default: begin
					REG_RDATA <= 8'h00;
				end
				endcase
			end
		end
	end

	// power-down controls
	assign CLOCK_POWER_DOWN         = shadow_lo_r[`SCSC_HL_CLK_OFF];
	assign ADC_POWER_DOWN           = shadow_lo_r[`SCSC_HL_ADC_OFF];
	assign COMPOSITE_DAC_POWER_DOWN = shadow_lo_r[`SCSC_HL_COMP_OFF];
	assign LUMA_CHROMA_DAC_POWER_DOWN = shadow_lo_r[`SCSC_HL_YC_OFF];

	// encoder filter and pedestal controls
	assign LUMA_NOTCH_INSERT        = shadow_lo_r[`SCSC_HL_NOTCH];
	assign CHROMA_BANDPASS_INSERT   = shadow_lo_r[`SCSC_HL_BANDPASS];
	assign BLACK_PEDESTAL_INSERT    = shadow_lo_r[`SCSC_HL_PEDESTAL];

	// output mode selection
	assign ENCODER_CLOCK_SOURCE =
		shadow_hi_r[`SCSC_HH_CLKSRC_LSB+1:`SCSC_HH_CLKSRC_LSB];
	assign SCAN_TYPE_SELECT   = shadow_hi_r[`SCSC_HH_SCAN];
	assign TV_STANDARD_SELECT = shadow_hi_r[`SCSC_HH_STD];
	assign OUTPUT_FORMAT =
		shadow_hi_r[`SCSC_HH_FMT_LSB+1:`SCSC_HH_FMT_LSB];

endmodule
